// ==== rtl/epic_ctrl.sv ====
/*
  External-pin and pin-change interrupt controller with an APB register
  slave and the entry/return sequencer that paces the processor core.
  Assumes pins are asynchronous, core strobes are one-cycle pulses in
  pclk, and an APB master that holds a request until pready.
*/
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "epic_defs.svh"
module epic_ctrl #(
  parameter int GROUP_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] ext_pins,
  input wire logic [GROUP_W-1:0] change_pins_lower_group,
  input wire logic [GROUP_W-1:0] change_pins_upper_group,
  input wire epic_pkg::epic_core_in_t core_in,
  output epic_pkg::epic_core_out_t core_out,
  output logic irq
);
  // registers
  logic [1:0] ext_irq_mask;
  logic [1:0] ext_irq_flags;
  logic [1:0] pin_change_group_enable;
  logic [3:0] ext_sense_control_reg;
  logic [GROUP_W-1:0] change_pin_mask_lo;
  logic [GROUP_W-1:0] change_pin_mask_hi;
  logic [1:0] change_flags;
  logic [2:0] ev_status;
  logic [2:0] ev_enable;
  // synchronisers
  logic [1:0] ext_s1, ext_s2, ext_s3;
  logic [GROUP_W-1:0] lo_s1, lo_s2, lo_s3;
  logic [GROUP_W-1:0] hi_s1, hi_s2, hi_s3;
  // sequencer
  epic_pkg::epic_state_t state;
  logic [2:0] cnt;
  logic [2:0] vec;
  logic gie;
  logic sei_shadow;
  // bus decode
  logic acc, wr_en;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  // detection and arbitration
  logic [1:0] ext_trig, ext_level, ext_pend;
  logic [1:0] pc_change, pc_pend;
  logic take, ret_start, ret_last;
  logic [2:0] take_vec;
  logic [1:0] auto_clr_ext, auto_clr_pc;
  logic [2:0] ev_set, next_ev_status;

  // any documented offset answers, everything else is a slave error
  function automatic logic epic_hit(input logic [7:0] a);
    epic_hit = (a == `EPIC_OFF_EXT_MASK) || (a == `EPIC_OFF_EXT_FLAGS) ||
               (a == `EPIC_OFF_GRP_EN) || (a == `EPIC_OFF_SENSE) ||
               (a == `EPIC_OFF_PMASK_LO) || (a == `EPIC_OFF_PMASK_HI) ||
               (a == `EPIC_OFF_PC_FLAGS) || (a == `EPIC_OFF_CORE_STATE) ||
               (a == `EPIC_OFF_EV_STATUS) || (a == `EPIC_OFF_EV_CLEAR) ||
               (a == `EPIC_OFF_EV_ENABLE);
  endfunction

  // edge/change decode per sense code; level code never triggers an edge
  function automatic logic epic_trig(input logic [1:0] sns,
                                     input logic cur,
                                     input logic prev);
    case (sns)
      `EPIC_SNS_ANY: epic_trig = cur ^ prev;
      `EPIC_SNS_FALL: epic_trig = prev & ~cur;
      `EPIC_SNS_RISE: epic_trig = cur & ~prev;
      default: epic_trig = 1'b0;
    endcase
  endfunction

  // write-enable for one register offset at the completing edge
  function automatic logic epic_wr(input logic en,
                                   input logic [7:0] a,
                                   input logic [7:0] off);
    epic_wr = en && (a == off);
  endfunction

  // apb: one wait state so prdata and pslverr come from flops
  assign acc = psel & penable;
  assign wr_en = acc & pready & pwrite;
  assign wbyte = pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= acc & ~pready;
    end
  end

  // read mux; unused upper bits read as zero
  always_comb begin
    rd_byte = `EPIC_RST_BYTE;
    unique case (paddr)
      `EPIC_OFF_EXT_MASK: rd_byte = {6'h00, ext_irq_mask};
      `EPIC_OFF_EXT_FLAGS: rd_byte = {6'h00, ext_irq_flags};
      `EPIC_OFF_GRP_EN: rd_byte = {6'h00, pin_change_group_enable};
      `EPIC_OFF_SENSE: rd_byte = {4'h0, ext_sense_control_reg};
      `EPIC_OFF_PMASK_LO: rd_byte = change_pin_mask_lo;
      `EPIC_OFF_PMASK_HI: rd_byte = change_pin_mask_hi;
      `EPIC_OFF_PC_FLAGS: rd_byte = {6'h00, change_flags};
      `EPIC_OFF_CORE_STATE: rd_byte = {state[4:0], sei_shadow, 1'b0, gie};
      `EPIC_OFF_EV_STATUS: rd_byte = {5'h00, ev_status};
      `EPIC_OFF_EV_ENABLE: rd_byte = {5'h00, ev_enable};
      default: rd_byte = `EPIC_RST_BYTE;
    endcase
  end

  // read data and error latched in the wait cycle, stable at pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (acc & ~pready) begin
      prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      pslverr <= ~epic_hit(paddr);
    end
  end

  // plain read/write configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_mask <= `EPIC_RST_TWO;
      pin_change_group_enable <= `EPIC_RST_TWO;
      ext_sense_control_reg <= `EPIC_RST_SENSE;
      change_pin_mask_lo <= {GROUP_W{1'b0}};
      change_pin_mask_hi <= {GROUP_W{1'b0}};
      ev_enable <= `EPIC_RST_EV;
    end else begin
      if (epic_wr(wr_en, paddr, `EPIC_OFF_EXT_MASK))
        ext_irq_mask <= wbyte[1:0];
      if (epic_wr(wr_en, paddr, `EPIC_OFF_GRP_EN))
        pin_change_group_enable <= wbyte[1:0];
      if (epic_wr(wr_en, paddr, `EPIC_OFF_SENSE))
        ext_sense_control_reg <= wbyte[3:0];
      if (epic_wr(wr_en, paddr, `EPIC_OFF_PMASK_LO))
        change_pin_mask_lo <= wbyte[GROUP_W-1:0];
      if (epic_wr(wr_en, paddr, `EPIC_OFF_PMASK_HI))
        change_pin_mask_hi <= wbyte[GROUP_W-1:0];
      if (epic_wr(wr_en, paddr, `EPIC_OFF_EV_ENABLE))
        ev_enable <= wbyte[2:0];
    end
  end

  // three-flop synchronisers; stage one feeds only stage two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1 <= 2'h0;
      ext_s2 <= 2'h0;
      ext_s3 <= 2'h0;
      lo_s1 <= {GROUP_W{1'b0}};
      lo_s2 <= {GROUP_W{1'b0}};
      lo_s3 <= {GROUP_W{1'b0}};
      hi_s1 <= {GROUP_W{1'b0}};
      hi_s2 <= {GROUP_W{1'b0}};
      hi_s3 <= {GROUP_W{1'b0}};
    end else begin
      ext_s1 <= ext_pins; // pin level regardless of direction
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      lo_s1 <= change_pins_lower_group;
      lo_s2 <= lo_s1;
      lo_s3 <= lo_s2;
      hi_s1 <= change_pins_upper_group;
      hi_s2 <= hi_s1;
      hi_s3 <= hi_s2;
    end
  end

  // masked change detection per group
  assign pc_change[`EPIC_BIT_LO] = |((lo_s2 ^ lo_s3) & change_pin_mask_lo);
  assign pc_change[`EPIC_BIT_HI] = |((hi_s2 ^ hi_s3) & change_pin_mask_hi);
  assign pc_pend = change_flags & pin_change_group_enable;

  // per external channel: trigger, level request and flag
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ext
      logic [1:0] sns;
      logic clr;
      assign sns = ext_sense_control_reg[2*gi+1:2*gi];
      assign ext_trig[gi] = epic_trig(sns, ext_s2[gi], ext_s3[gi]);
      assign ext_level[gi] = (sns == `EPIC_SNS_LEVEL);
      assign clr = (wr_en && (paddr == `EPIC_OFF_EXT_FLAGS) && wbyte[gi]) ||
                   auto_clr_ext[gi];
      // low level requests directly; edges go through the flag
      assign ext_pend[gi] = ext_irq_mask[gi] &
                            (ext_level[gi] ? ~ext_s2[gi] : ext_irq_flags[gi]);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ext_irq_flags[gi] <= 1'b0;
        end else if (ext_level[gi]) begin
          ext_irq_flags[gi] <= 1'b0;
        end else if (ext_trig[gi]) begin
          ext_irq_flags[gi] <= 1'b1; // set beats clear
        end else if (clr) begin
          ext_irq_flags[gi] <= 1'b0;
        end
      end
    end
    for (gi = 0; gi < 2; gi++) begin : g_pc
      logic clr;
      assign clr = (wr_en && (paddr == `EPIC_OFF_PC_FLAGS) && wbyte[gi]) ||
                   auto_clr_pc[gi];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          change_flags[gi] <= 1'b0;
        end else if (pc_change[gi]) begin
          change_flags[gi] <= 1'b1;
        end else if (clr) begin
          change_flags[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // fixed priority: ext0, ext1, group lo, group hi
  always_comb begin
    take_vec = `EPIC_VEC_NONE;
    if (ext_pend[0])
      take_vec = `EPIC_VEC_EXT0;
    else if (ext_pend[1])
      take_vec = `EPIC_VEC_EXT1;
    else if (pc_pend[`EPIC_BIT_LO])
      take_vec = `EPIC_VEC_PC0;
    else if (pc_pend[`EPIC_BIT_HI])
      take_vec = `EPIC_VEC_PC1;
  end

  // accept only between instructions or from sleep, never in sei shadow
  assign ret_start = (state == epic_pkg::EPIC_ST_IDLE) & core_in.reti;
  assign take = (state == epic_pkg::EPIC_ST_IDLE) & ~core_in.reti & gie &
                ~sei_shadow &
                (core_in.instr_done | core_in.sleeping) &
                (take_vec != `EPIC_VEC_NONE);
  assign ret_last = (state == epic_pkg::EPIC_ST_RET) &&
                    (cnt == `EPIC_CNT_ZERO);

  // flags of the source taken clear on entry
  assign auto_clr_ext[0] = take && (take_vec == `EPIC_VEC_EXT0);
  assign auto_clr_ext[1] = take && (take_vec == `EPIC_VEC_EXT1);
  assign auto_clr_pc[`EPIC_BIT_LO] = take && (take_vec == `EPIC_VEC_PC0);
  assign auto_clr_pc[`EPIC_BIT_HI] = take && (take_vec == `EPIC_VEC_PC1);

  // global enable and the one-instruction shadow after sei
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie <= 1'b0;
      sei_shadow <= 1'b0;
    end else begin
      if (ret_last)
        gie <= 1'b1;
      else if (take | core_in.cli)
        gie <= 1'b0;
      else if (core_in.sei)
        gie <= 1'b1;
      if (core_in.sei)
        sei_shadow <= 1'b1;
      else if (core_in.instr_done)
        sei_shadow <= 1'b0; // next instruction done, window opens
    end
  end

  // entry, wake, jump and return sequencer with its core controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= epic_pkg::EPIC_ST_IDLE;
      cnt <= `EPIC_CNT_ZERO;
      vec <= `EPIC_VEC_NONE;
      core_out <= '0;
    end else begin
      core_out.vector_fetch <= 1'b0;
      core_out.sp_inc_two <= 1'b0;
      core_out.gie <= gie;
      unique case (state)
        epic_pkg::EPIC_ST_IDLE: begin
          core_out.hold <= 1'b0;
          core_out.pc_push <= 1'b0;
          core_out.pc_pop <= 1'b0;
          core_out.jump_busy <= 1'b0;
          if (ret_start) begin
            state <= epic_pkg::EPIC_ST_RET;
            cnt <= `EPIC_RET_CYC - `EPIC_CNT_ONE;
            core_out.hold <= 1'b1;
            core_out.pc_pop <= 1'b1;
          end else if (take && core_in.sleeping) begin
            state <= epic_pkg::EPIC_ST_WAKE;
            cnt <= `EPIC_WAKE_CYC - `EPIC_CNT_ONE;
            vec <= take_vec;
            core_out.hold <= 1'b1;
          end else if (take) begin
            state <= epic_pkg::EPIC_ST_ENTRY;
            cnt <= `EPIC_ENTRY_CYC - `EPIC_CNT_ONE;
            vec <= take_vec;
            core_out.hold <= 1'b1;
            core_out.pc_push <= 1'b1;
          end
        end
        epic_pkg::EPIC_ST_WAKE: begin
          if (cnt == `EPIC_CNT_ZERO) begin
            state <= epic_pkg::EPIC_ST_ENTRY;
            cnt <= `EPIC_ENTRY_CYC - `EPIC_CNT_ONE;
            core_out.pc_push <= 1'b1;
          end else begin
            cnt <= cnt - `EPIC_CNT_ONE;
          end
        end
        epic_pkg::EPIC_ST_ENTRY: begin
          if (cnt == `EPIC_CNT_ZERO) begin
            state <= epic_pkg::EPIC_ST_JUMP;
            cnt <= `EPIC_JUMP_CYC - `EPIC_CNT_ONE;
            core_out.pc_push <= 1'b0;
            core_out.vector_fetch <= 1'b1;
            core_out.vector_id <= vec;
            core_out.jump_busy <= 1'b1;
          end else begin
            cnt <= cnt - `EPIC_CNT_ONE;
          end
        end
        epic_pkg::EPIC_ST_JUMP: begin
          if (cnt == `EPIC_CNT_ZERO) begin
            state <= epic_pkg::EPIC_ST_IDLE;
            core_out.jump_busy <= 1'b0;
            core_out.hold <= 1'b0;
          end else begin
            cnt <= cnt - `EPIC_CNT_ONE;
          end
        end
        epic_pkg::EPIC_ST_RET: begin
          if (cnt == `EPIC_CNT_ZERO) begin
            state <= epic_pkg::EPIC_ST_IDLE;
            core_out.pc_pop <= 1'b0;
            core_out.hold <= 1'b0;
          end else begin
            cnt <= cnt - `EPIC_CNT_ONE;
            if (cnt == `EPIC_CNT_ONE)
              core_out.sp_inc_two <= 1'b1; // in the last cycle
          end
        end
        default: begin
          state <= epic_pkg::EPIC_ST_IDLE;
        end
      endcase
    end
  end

  // sticky events; a set in the clearing cycle survives
  assign ev_set[`EPIC_EV_ENTRY] = take;
  assign ev_set[`EPIC_EV_RET] = ret_last;
  assign ev_set[`EPIC_EV_WAKE] = take & core_in.sleeping;
  always_comb begin
    next_ev_status = ev_status;
    if (epic_wr(wr_en, paddr, `EPIC_OFF_EV_CLEAR))
      next_ev_status = ev_status & ~wbyte[2:0];
    next_ev_status = next_ev_status | ev_set;
  end

  // irq tracks next status so it never lags the sticky bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_status <= `EPIC_RST_EV;
      irq <= 1'b0;
    end else begin
      ev_status <= next_ev_status;
      irq <= |(next_ev_status & ev_enable);
    end
  end

endmodule // epic_ctrl

// ==== rtl/epic_defs.svh ====
/*
  Constants of the external-pin and pin-change interrupt controller:
  APB offsets, reset values, field positions, sense codes and cycle counts.
  Assumes inclusion by bare name from the design module and the bench.
*/
`ifndef EPIC_DEFS_SVH
`define EPIC_DEFS_SVH
// register byte offsets
`define EPIC_OFF_EXT_MASK 8'h00
`define EPIC_OFF_EXT_FLAGS 8'h04
`define EPIC_OFF_GRP_EN 8'h08
`define EPIC_OFF_SENSE 8'h0C
`define EPIC_OFF_PMASK_LO 8'h10
`define EPIC_OFF_PMASK_HI 8'h14
`define EPIC_OFF_PC_FLAGS 8'h18
`define EPIC_OFF_CORE_STATE 8'h1C
`define EPIC_OFF_EV_STATUS 8'h20
`define EPIC_OFF_EV_CLEAR 8'h24
`define EPIC_OFF_EV_ENABLE 8'h28
// reset values
`define EPIC_RST_BYTE 8'h00
`define EPIC_RST_TWO 2'h0
`define EPIC_RST_SENSE 4'h0
`define EPIC_RST_EV 3'h0
// field positions
`define EPIC_BIT_LO 0
`define EPIC_BIT_HI 1
`define EPIC_EV_ENTRY 0
`define EPIC_EV_RET 1
`define EPIC_EV_WAKE 2
// sense-control codes
`define EPIC_SNS_LEVEL 2'h0
`define EPIC_SNS_ANY 2'h1
`define EPIC_SNS_FALL 2'h2
`define EPIC_SNS_RISE 2'h3
// sequence lengths in cycles, loaded as count minus one
`define EPIC_ENTRY_CYC 3'h4
`define EPIC_WAKE_CYC 3'h4
`define EPIC_JUMP_CYC 3'h3
`define EPIC_RET_CYC 3'h4
`define EPIC_CNT_ONE 3'h1
`define EPIC_CNT_ZERO 3'h0
// vector numbers
`define EPIC_VEC_NONE 3'h0
`define EPIC_VEC_EXT0 3'h1
`define EPIC_VEC_EXT1 3'h2
`define EPIC_VEC_PC0 3'h3
`define EPIC_VEC_PC1 3'h4
`endif

// ==== rtl/epic_pkg.sv ====
/*
  Types of the interrupt controller: core-facing structs and the sequencer
  state encoding. Assumes epic_defs.svh is on the include path.
*/
package epic_pkg;
  // strobes and levels from the processor core
  typedef struct packed {
    logic instr_done;
    logic sei;
    logic cli;
    logic reti;
    logic sleeping;
  } epic_core_in_t;
  // sequencing controls towards the processor core
  typedef struct packed {
    logic hold;
    logic pc_push;
    logic pc_pop;
    logic sp_inc_two;
    logic vector_fetch;
    logic [2:0] vector_id;
    logic jump_busy;
    logic gie;
  } epic_core_out_t;
  typedef enum logic [4:0] {
    EPIC_ST_IDLE = 5'h01,
    EPIC_ST_WAKE = 5'h02,
    EPIC_ST_ENTRY = 5'h04,
    EPIC_ST_JUMP = 5'h08,
    EPIC_ST_RET = 5'h10
  } epic_state_t;
endpackage

// ==== verif/epic_core_model.sv ====
/*
  Processor core stand-in: ends instructions at a chosen pace, stalls on
  hold, issues enable, disable and return strobes on the bench's request.
  Assumes the bench changes op, op_go, gap and sleep_lvl after a rising edge.
*/
`timescale 1ns/10ps
module epic_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire epic_pkg::epic_core_out_t core_out,
  input wire logic [1:0] op,
  input wire logic op_go,
  input wire logic sleep_lvl,
  input wire logic [1:0] gap,
  output epic_pkg::epic_core_in_t core_in
);
  logic [1:0] cnt, pend;
  logic fin;
  // an instruction ends every gap+1 cycles unless stalled or asleep
  assign fin = !core_out.hold && !sleep_lvl && cnt == gap;
  // pace counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 2'h0;
    end else begin
      cnt <= fin ? 2'h0 : cnt + 2'h1;
    end
  end
  // a requested op waits for the next instruction end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 2'h0;
    end else begin
      pend <= op_go ? op : (fin ? 2'h0 : pend);
    end
  end
  // strobes ride on instruction ends, so the one after enable still runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_in <= '0;
    end else begin
      core_in.instr_done <= fin;
      core_in.sei <= fin && pend == 2'h1;
      core_in.cli <= fin && pend == 2'h2;
      core_in.reti <= fin && pend == 2'h3;
      core_in.sleeping <= sleep_lvl;
    end
  end
endmodule // epic_core_model

// ==== verif/epic_ctrl_assertions.sv ====
/*
  Port checker of the interrupt controller: sequencer spans, enable shadow,
  vector codes and APB answer timing.
  Assumes one clock domain and the core strobes of the bench's core model.
*/
`timescale 1ns/10ps
module epic_ctrl_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire epic_pkg::epic_core_in_t core_in,
  input wire epic_pkg::epic_core_out_t core_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // entry pushes for four cycles, then fetches the vector
  AST_ENTRY_PUSH: assert property ($rose(core_out.pc_push) |->
    core_out.pc_push[*4] ##1 (!core_out.pc_push && core_out.vector_fetch))
    else $error("entry push span wrong");
  AST_JUMP_THREE: assert property ($rose(core_out.jump_busy) |->
    core_out.jump_busy[*3] ##1 !core_out.jump_busy)
    else $error("jump span wrong");
  AST_HOLD_SPAN: assert property ($rose(core_out.pc_push) |->
    core_out.hold[*7] ##1 !core_out.hold)
    else $error("core hold span wrong");
  // wake adds four hold-only cycles ahead of the push
  AST_WAKE_FOUR: assert property ($rose(core_out.hold) &&
    !core_out.pc_push && !core_out.pc_pop |->
    (core_out.hold && !core_out.pc_push)[*4] ##1 core_out.pc_push)
    else $error("wake span wrong");
  AST_RET_FOUR: assert property ($rose(core_out.pc_pop) |->
    core_out.pc_pop[*4] ##1 !core_out.pc_pop)
    else $error("return span wrong");
  AST_RET_STACK: assert property ($rose(core_out.pc_pop) |->
    !core_out.sp_inc_two[*3] ##1 core_out.sp_inc_two ##2 core_out.gie)
    else $error("return stack step or enable wrong");
  // one more instruction runs after enable before any entry
  AST_SEI_SHADOW: assert property (core_in.sei && !core_out.gie &&
    !core_out.hold |=> !core_out.hold[*2])
    else $error("entry inside enable shadow");
  AST_VEC_CODE: assert property (core_out.vector_fetch |->
    core_out.vector_id != 3'h0 && core_out.vector_id <= 3'h4)
    else $error("vector code out of range");
  AST_APB_WAIT: assert property ($rose(penable) && psel |->
    !pready ##1 pready ##1 !pready)
    else $error("apb wait state wrong");
  AST_APB_UNMAPPED: assert property (psel && penable && pready &&
    paddr > 8'h28 |-> pslverr)
    else $error("unmapped access without error");
endmodule // epic_ctrl_chk

bind epic_ctrl epic_ctrl_chk epic_ctrl_chk_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .core_in(core_in),
  .core_out(core_out));

// ==== verif/test_ext_pin_interrupt_ctrl.sv ====
/*
  Self-checking bench of the interrupt controller: APB master, pins and
  core model. Assumes epic_defs.svh on the include path.
*/
`timescale 1ns/10ps
`include "epic_defs.svh"
module test_ext_pin_interrupt_ctrl;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, err, irq, op_go = 1'b0;
  logic sleep_lvl = 1'b0;
  logic [7:0] paddr = 8'h00, lo_pins = 8'h00, hi_pins = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, m, r;
  logic [31:0] rng = 32'hB93E73B4;
  logic [1:0] ext_pins = 2'h0, op = 2'h0, gap = 2'h0;
  epic_pkg::epic_core_in_t core_in;
  epic_pkg::epic_core_out_t core_out;
  int n_mismatch = 0, checked = 0;

  // 10 MHz clock
  always #50 pclk = ~pclk;

  epic_ctrl epic_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_pins(ext_pins), .change_pins_lower_group(lo_pins),
    .change_pins_upper_group(hi_pins), .core_in(core_in),
    .core_out(core_out), .irq(irq));
  epic_core_model epic_core_model_inst (.pclk(pclk), .presetn(presetn),
    .core_out(core_out), .op(op), .op_go(op_go), .sleep_lvl(sleep_lvl),
    .gap(gap), .core_in(core_in));

  // xorshift source, fixed start so runs repeat
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  // whether one pin edge sets the flag under a sense code
  function automatic logic edge_hit(input logic [1:0] c, input logic up);
    return c == `EPIC_SNS_ANY || c == (up ? `EPIC_SNS_RISE : `EPIC_SNS_FALL);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask
  // one APB transfer; holds everything until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) chk(32'h0, 32'h1, "no pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                     input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask
  // three sync stages plus flag update, with margin
  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask
  // core op at a random pace, then wait for the global enable to follow
  task automatic core_op(input logic [1:0] o, input logic want);
    int n;
    n = 0;
    r = xs();
    @(posedge pclk);
    op <= o;
    op_go <= 1'b1;
    gap <= r[1:0];
    @(posedge pclk);
    op_go <= 1'b0;
    while (core_out.gie !== want && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(core_out.gie), 32'(want), "global enable");
  endtask
  task automatic wait_fetch(input logic [2:0] id);
    int n;
    n = 0;
    while (core_out.vector_fetch !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(core_out.vector_fetch), 32'h1, "vector fetch");
    chk(32'(core_out.vector_id), 32'(id), "vector");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // watchdog: the run needs under a thousand cycles
  initial begin
    #(20000 * 100);
    n_mismatch++;
    summarize();
  end

  // main sequence
  initial begin
    int i, k;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 7; i++) rdc(8'(4 * i), 32'h0, "reset value");
    rdc(8'h1C, 32'h08, "core state idle");
    rdc(8'h40, 32'h0, "unmapped read");
    chk(32'(err), 32'h1, "unmapped error");
    wr(8'h08, 32'hFF);
    rdc(8'h08, 32'h03, "group enable width");
    wr(8'h08, 32'h00);
    $display("test registers done");
    for (k = 0; k < 2; k++) for (i = 0; i < 4; i++) begin
      wr(8'h0C, 32'(i) << (2 * k));
      ext_pins[k] <= 1'b1;
      settle();
      rdc(8'h04, 32'(edge_hit(2'(i), 1'b1)) << k, "rise flag");
      wr(8'h04, 32'h0);
      rdc(8'h04, 32'(edge_hit(2'(i), 1'b1)) << k, "zero write");
      wr(8'h04, 32'h3);
      rdc(8'h04, 32'h0, "flag cleared");
      ext_pins[k] <= 1'b0;
      settle();
      rdc(8'h04, 32'(edge_hit(2'(i), 1'b0)) << k, "fall flag");
      wr(8'h04, 32'h3);
    end
    // a flag caught in edge mode must drop once the input is level-sensed
    wr(8'h0C, 32'h1);
    ext_pins[0] <= 1'b1;
    settle();
    rdc(8'h04, 32'h1, "any-edge flag");
    wr(8'h0C, 32'h0);
    rdc(8'h04, 32'h0, "level forces flag low");
    ext_pins[0] <= 1'b0;
    settle();
    $display("test sense codes done");
    for (i = 0; i < 8; i++) begin
      m = xs();
      r = xs();
      if (i == 0) m[7:0] = 8'h00;
      wr(8'h10, {24'h0, m[7:0]});
      wr(8'h14, {24'h0, m[15:8]});
      lo_pins <= lo_pins ^ r[7:0];
      hi_pins <= hi_pins ^ r[15:8];
      settle();
      rdc(8'h18, {30'h0, |(m[15:8] & r[15:8]), |(m[7:0] & r[7:0])},
        "change flags");
      wr(8'h18, 32'h3);
    end
    $display("test pin masks done");
    wr(8'h0C, 32'h3);
    core_op(2'h1, 1'b1);
    ext_pins[0] <= 1'b1;
    settle();
    chk(32'(core_out.hold), 32'h0, "taken while masked");
    rdc(8'h04, 32'h1, "flag while masked");
    wr(8'h04, 32'h3);
    for (k = 0; k < 2; k++) begin
      wr(8'h08, 32'h1 << k);
      wr(8'h10 + 8'(4 * k), 32'h1);
      if (k == 0) lo_pins[0] <= ~lo_pins[0];
      else hi_pins[0] <= ~hi_pins[0];
      wait_fetch(3'(`EPIC_VEC_PC0 + k));
      rdc(8'h18, 32'h0, "auto clear on entry");
      core_op(2'h3, 1'b1);
    end
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'hC);
    wr(8'h00, 32'h2);
    sleep_lvl <= 1'b1;
    ext_pins[1] <= 1'b1;
    wait_fetch(`EPIC_VEC_EXT1);
    sleep_lvl <= 1'b0;
    rdc(8'h04, 32'h0, "ext flag auto clear");
    core_op(2'h3, 1'b1);
    $display("test entries done");
    rdc(8'h20, 32'h7, "event status");
    chk(32'(irq), 32'h0, "irq while disabled");
    wr(8'h28, 32'h7);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1, "irq raised");
    wr(8'h24, 32'h7);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0, "irq cleared");
    rdc(8'h20, 32'h0, "status cleared");
    $display("test events done");
    // request already pending when sei runs: one more instruction first
    core_op(2'h2, 1'b0);
    wr(8'h08, 32'h1);
    lo_pins[0] <= ~lo_pins[0];
    settle();
    chk(32'(core_out.hold), 32'h0, "taken while disabled");
    core_op(2'h1, 1'b1);
    wait_fetch(`EPIC_VEC_PC0);
    core_op(2'h3, 1'b1);
    $display("test enable shadow done");
    summarize();
  end
endmodule // test_ext_pin_interrupt_ctrl
